// file: src/interval_timer_defines.vh
// constants for the three channel interval timer
`ifndef INTERVAL_TIMER_DEFINES_VH
`define INTERVAL_TIMER_DEFINES_VH
// ***************
// port addresses
// ***************
`define IT_CNT0_ADDR 16'h0040
`define IT_CNT1_ADDR 16'h0041
`define IT_CNT2_ADDR 16'h0042
`define IT_CTRL_ADDR 16'h0043
`define IT_GATE_ADDR 16'h0061
// ***************
// control word fields
// ***************
`define IT_SEL_HI    7
`define IT_SEL_LO    6
`define IT_RW_HI     5
`define IT_RW_LO     4
`define IT_MODE_HI   3
`define IT_MODE_LO   1
`define IT_BCD_BIT   0
`define IT_SEL_RDBK  2'h3
`define IT_RW_LATCH  2'h0
`define IT_RW_LSB    2'h1
`define IT_RW_MSB    2'h2
`define IT_RW_BOTH   2'h3
`define IT_GATE_BIT  0
// ***************
// reset values and counts
// ***************
`define IT_CTRL_RST  6'h00
`define IT_CNT_RST   16'h0000
`define IT_OSC_DIV   12
`endif

// file: src/interval_timer.v
// three channel 16-bit interval timer with host i/o port decode
// What this block does
// RULE1: three independent 16-bit down counters, binary or bcd, timer or counter use
// RULE2: all counters step on one count clock, oscillator divided by twelve
// RULE3: written bytes sit in holding latches, loaded on next count clock fall; modes 1, 5 wait for a trigger, running 2, 3 for period end
// RULE4: output latches capture low and high count bytes for host reads
// RULE5: latched status holds control bits, output level and null count flag
// RULE6: modes 0, 1, 4, 5 wrap past zero to ffff or 9999
// RULE7: modes 2 and 3 reload the initial count each period
// RULE8: tick counter output feeds the interrupt controller input zero
// RULE9: refresh pacing counter output paces dram refresh
// RULE10: tone counter drives speaker, gated by bit 0 of port 0061
// RULE11: gates of counters 0 and 1 tied high; counter 2 has all modes
// RULE12: ports 0040 to 0042 are counter data, 0043 is write-only control
// RULE13: control word resets that counter's logic and sets output level
// RULE14: host writes control word first, then count in selected format
// RULE15: new counts accepted anytime in the same format, mode kept
// RULE16: access formats are low only, high only, or low then high
// RULE17: control word write clears the input holding latches
// RULE18: control word has command bits 7:4, mode 3:1, bcd bit 0
// RULE19: bits 7:6 pick counter or read-back, bits 5:4 pick latch or format
// RULE20: mode 000 is 0, 001 is 1, x10 is 2, x11 is 3
// RULE21: read-back bit 5 low latches count, bit 4 low latches status
`include "interval_timer_defines.vh"
module interval_timer #(
  parameter OSC_DIV = `IT_OSC_DIV
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  // oscillator, sampled as a level
  input  wire        system_oscillator_clock_i,
  // host i/o port
  input  wire [15:0] io_addr_i,
  input  wire        io_wr_i,
  input  wire        io_rd_i,
  input  wire [7:0]  io_wdata_i,
  output reg  [7:0]  io_rdata_o,
  output reg         io_rd_ack_o,
  // counter outputs
  output wire        timer_interrupt_input_o,
  output wire        refresh_pacing_o,
  output wire        tone_o
);

  // ****************************************
  // decode helpers
  // ****************************************
  function [2:0] mode_of;
    input [2:0] f;
    begin
      if (f[1])
        mode_of = {2'b01, f[0]};  // see RULE20
      else
        mode_of = {f[2], 1'b0, f[0]};
    end
  endfunction

  // bcd steps borrow digit by digit, so 0000 wraps to 9999
  function [15:0] dec_val;
    input [15:0] v;
    input        bcd;
    integer      k;
    reg          borrow;
    begin
      dec_val = v - 16'h0001;
      borrow  = 1'b1;
      if (bcd)
      begin
        dec_val = v;
        for (k = 0; k < 4; k = k + 1)
        begin
          if (borrow)
          begin
            if (v[4*k+:4] == 4'h0)
              dec_val[4*k+:4] = 4'h9;  // see RULE6
            else
            begin
              dec_val[4*k+:4] = v[4*k+:4] - 4'h1;
              borrow          = 1'b0;
            end
          end
        end
      end
    end
  endfunction

  // ****************************************
  // count clock divider
  // ****************************************
  reg       osc_d;
  reg [3:0] div_cnt;
  reg       ce;
  wire      osc_rise = system_oscillator_clock_i & ~osc_d;

  // divider end points, cut to the divider width on purpose
  localparam integer DIV_LAST_I = OSC_DIV - 1;
  localparam integer DIV_HALF_I = OSC_DIV / 2 - 1;
  localparam [3:0]   DIV_LAST   = DIV_LAST_I[3:0];
  localparam [3:0]   DIV_HALF   = DIV_HALF_I[3:0];

  // ce marks the falling edge of the divided count clock
  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      osc_d   <= 1'b0;
      div_cnt <= 4'h0;
      ce      <= 1'b0;
    end
    else
    begin
      osc_d <= system_oscillator_clock_i;
      ce    <= osc_rise && (div_cnt == DIV_HALF);  // see RULE2
      if (osc_rise)
        div_cnt <= (div_cnt == DIV_LAST) ? 4'h0 : div_cnt + 4'h1;
    end
  end

  // ****************************************
  // host port decode
  // ****************************************
  reg        tone_gate;
  wire       cw_wr   = io_wr_i && (io_addr_i == `IT_CTRL_ADDR);  // see RULE12
  wire [1:0] cw_sel  = io_wdata_i[`IT_SEL_HI:`IT_SEL_LO];  // see RULE19
  wire [1:0] cw_rw   = io_wdata_i[`IT_RW_HI:`IT_RW_LO];
  wire       dat_hit = (io_addr_i[15:2] == `IT_CNT0_ADDR >> 2) && (io_addr_i[1:0] != 2'h3);
  wire [1:0] dat_sel = io_addr_i[1:0];
  wire [2:0] gate_w  = {tone_gate, 2'b11};  // see RULE11
  wire [7:0] rd_byte [0:2];
  wire [2:0] out_w;

  always @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      tone_gate   <= 1'b0;
      io_rdata_o  <= 8'h00;
      io_rd_ack_o <= 1'b0;
    end
    else
    begin
      if (io_wr_i && io_addr_i == `IT_GATE_ADDR)
        tone_gate <= io_wdata_i[`IT_GATE_BIT];  // see RULE10
      // only data ports answer, so a stray read of a write-only port has no side effect
      io_rd_ack_o <= io_rd_i && dat_hit;
      if (io_rd_i && dat_hit)
        io_rdata_o <= rd_byte[dat_sel];
    end
  end

  // ****************************************
  // counter channels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : chan
      // ****************************************
      // channel state
      // ****************************************
      reg  [5:0]  ctrl;
      reg  [15:0] count;  // see RULE1
      reg  [15:0] init;
      reg  [15:0] olr;
      reg  [7:0]  stat;
      reg         out;
      reg         nullc;
      reg         wphase;
      reg         rphase;
      reg         olr_v;
      reg         stat_v;
      reg         loaded;
      reg         pend;
      reg         trig;
      reg         gate_d;

      // ****************************************
      // channel decode
      // ****************************************
      wire        gate   = gate_w[g];
      wire        rise   = gate & ~gate_d;
      wire        trg    = trig | rise;
      wire [2:0]  m      = mode_of(ctrl[3:1]);
      wire [1:0]  fmt    = ctrl[5:4];
      wire        bcd    = ctrl[`IT_BCD_BIT];
      wire        m_hw   = (m == 3'd1) || (m == 3'd5);
      wire        m_per  = (m == 3'd2) || (m == 3'd3);
      wire        en     = m_hw | gate;
      wire        at_end = (m == 3'd3) ? (count == 16'h0002) : (count == 16'h0001);
      wire        dw     = io_wr_i && dat_hit && (dat_sel == g);
      wire        rd     = io_rd_i && dat_hit && (dat_sel == g);
      wire        rb     = cw_wr && (cw_sel == `IT_SEL_RDBK) && io_wdata_i[g+1];
      wire        lat_c  = (cw_wr && cw_sel == g && cw_rw == `IT_RW_LATCH) || (rb && !io_wdata_i[5]);
      wire        lat_s  = rb && !io_wdata_i[4];  // see RULE21
      wire        cw_me  = cw_wr && (cw_sel == g) && (cw_rw != `IT_RW_LATCH);
      wire        full   = dw && (fmt != `IT_RW_BOTH || wphase);
      wire        ld     = m_hw ? (trg && (loaded || pend))
                         : m_per ? (gate && ((pend && !loaded) || (trg && (loaded || pend))
                                             || (loaded && at_end)))
                         : (pend && !wphase);
      wire [15:0] src    = olr_v ? olr : count;
      wire        hi_b   = (fmt == `IT_RW_MSB) || (fmt == `IT_RW_BOTH && rphase);
      assign rd_byte[g] = stat_v ? stat : (hi_b ? src[15:8] : src[7:0]);  // see RULE4
      assign out_w[g]   = out;

      // ****************************************
      // channel registers
      // ****************************************
      always @(posedge clk_i)
      begin
        if (!resetn_i)
        begin
          ctrl   <= `IT_CTRL_RST;
          count  <= `IT_CNT_RST;
          init   <= `IT_CNT_RST;
          olr    <= `IT_CNT_RST;
          stat   <= 8'h00;
          out    <= 1'b0;
          nullc  <= 1'b1;
          wphase <= 1'b0;
          rphase <= 1'b0;
          olr_v  <= 1'b0;
          stat_v <= 1'b0;
          loaded <= 1'b0;
          pend   <= 1'b0;
          trig   <= 1'b0;
          // gates rest at their idle level so release brings no false edge
          gate_d <= (g != 2);
        end
        else if (cw_me)
        begin
          ctrl   <= io_wdata_i[5:0];  // see RULE18
          out    <= (mode_of(io_wdata_i[3:1]) != 3'd0);  // see RULE13
          init   <= `IT_CNT_RST;  // see RULE17
          nullc  <= 1'b1;
          wphase <= 1'b0;
          rphase <= 1'b0;
          olr_v  <= 1'b0;
          stat_v <= 1'b0;
          loaded <= 1'b0;
          pend   <= 1'b0;
          trig   <= 1'b0;
          gate_d <= gate;
        end
        else
        begin
          gate_d <= gate;
          // a gate edge landing on the consuming tick is kept
          if (rise)
            trig <= 1'b1;
          else if (ce)
            trig <= 1'b0;
          // gate low ends a pulse at once in the periodic modes
          if (m_per && !gate)
            out <= 1'b1;
          if (ce && ld)
          begin
            count  <= (m == 3'd3) ? {init[15:1], 1'b0} : init;  // see RULE3
            pend   <= 1'b0;
            nullc  <= 1'b0;
            loaded <= 1'b1;
            case (m)
              3'd1:    out <= 1'b0;
              3'd3:    out <= (loaded && at_end && !trg) ? ~out : 1'b1;  // see RULE7
              3'd5:    out <= out;
              3'd0:    out <= 1'b0;
              default: out <= 1'b1;
            endcase
          end
          else if (ce && loaded && en && !(m == 3'd0 && wphase))
          begin
            count <= (m == 3'd3) ? dec_val(dec_val(count, bcd), bcd) : dec_val(count, bcd);  // see RULE6
            case (m)
              3'd0, 3'd1: out <= out | (count == 16'h0001);
              3'd2:       out <= (count != 16'h0002);
              3'd3:       out <= out;
              default:    out <= (count != 16'h0001);
            endcase
          end
          // writes come after the tick so a new count is never lost
          if (dw)
          begin
            case (fmt)
              `IT_RW_LSB: init[7:0]  <= io_wdata_i;  // see RULE16
              `IT_RW_MSB: init[15:8] <= io_wdata_i;
              default:
              begin
                if (wphase)
                  init[15:8] <= io_wdata_i;
                else
                  init[7:0]  <= io_wdata_i;
                wphase <= ~wphase;
                if (!wphase && m == 3'd0)
                  out <= 1'b0;
              end
            endcase
          end
          if (full)
          begin
            pend  <= 1'b1;  // see RULE15
            nullc <= 1'b1;
            if (m == 3'd0)
              out <= 1'b0;
          end
          // a second latch before the read is ignored
          if (lat_c && !olr_v)
          begin
            olr   <= count;
            olr_v <= 1'b1;
          end
          if (lat_s && !stat_v)
          begin
            stat   <= {out, nullc, ctrl};  // see RULE5
            stat_v <= 1'b1;
          end
          if (rd)
          begin
            if (stat_v)
              stat_v <= 1'b0;
            else if (fmt == `IT_RW_BOTH)
            begin
              rphase <= ~rphase;
              if (rphase)
                olr_v <= 1'b0;
            end
            else
              olr_v <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // system connections
  // ****************************************
  assign timer_interrupt_input_o = out_w[0];  // see RULE8
  assign refresh_pacing_o        = out_w[1];  // see RULE9
  assign tone_o                  = out_w[2];  // see RULE10

endmodule // interval_timer

// file: bench/io_host_model.sv
// host processor model on the timer's 8-bit i/o port
module io_host_model (
  // clock
  input  wire         clk_i,
  // i/o port toward the timer
  output logic [15:0] io_addr_o,
  output logic        io_wr_o,
  output logic        io_rd_o,
  output logic [7:0]  io_wdata_o,
  input  wire  [7:0]  io_rdata_i,
  input  wire         io_rd_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    io_addr_o = 16'h0000;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
  end
  // idle lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_addr_o <= a;
    io_wdata_o <= d;
    io_wr_o <= 1'b1;
    @(posedge clk_i);
    io_wr_o <= 1'b0;
    io_addr_o <= ~a;
    io_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic k);
    @(posedge clk_i);
    io_addr_o <= a;
    io_rd_o <= 1'b1;
    @(posedge clk_i);
    io_rd_o <= 1'b0;
    io_addr_o <= ~a;
    // the answer stands in the cycle after the strobe; take it at that edge
    @(posedge clk_i);
    d = io_rdata_i;
    k = io_rd_ack_i;
  endtask
endmodule // io_host_model

// file: bench/interval_timer_checker.sv
// port assertions for the interval timer
module interval_timer_checker #(
  parameter OSC_DIV = 12
) (
  input wire        clk_i,
  input wire        resetn_i,
  input wire        system_oscillator_clock_i,
  input wire [15:0] io_addr_i,
  input wire        io_wr_i,
  input wire        io_rd_i,
  input wire [7:0]  io_wdata_i,
  input wire [7:0]  io_rdata_o,
  input wire        io_rd_ack_o,
  input wire        timer_interrupt_input_o,
  input wire        refresh_pacing_o,
  input wire        tone_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // cycles since the tick and refresh outputs last moved; count clock edges are a tick apart
  logic [7:0] gap0 = 8'hff;
  logic [7:0] gap1 = 8'hff;
  logic       q0 = 1'b0;
  logic       q1 = 1'b0;
  wire        cw = io_wr_i && io_addr_i == 16'h0043 && io_wdata_i[5:4] != 2'h0;
  always @(posedge clk_i)
  begin
    q0 <= timer_interrupt_input_o;
    q1 <= refresh_pacing_o;
    gap0 <= (q0 != timer_interrupt_input_o) ? 8'h00 : (gap0 == 8'hff) ? gap0 : gap0 + 8'h01;
    gap1 <= (q1 != refresh_pacing_o) ? 8'h00 : (gap1 == 8'hff) ? gap1 : gap1 + 8'h01;
  end
  a_ack_after_read: assert property (io_rd_i && io_addr_i >= 16'h0040 && io_addr_i <= 16'h0042 |=> io_rd_ack_o)
    else $error("data port read not acknowledged");
  a_no_ack_ctrl: assert property (io_rd_i && io_addr_i == 16'h0043 |=> !io_rd_ack_o)
    else $error("control port read acknowledged");
  a_rdata_hold: assert property (!$past(io_rd_i) |-> $stable(io_rdata_o))
    else $error("read data moved without a read");
  a_tick_cw_low: assert property (cw && io_wdata_i[7:6] == 2'h0 && io_wdata_i[3:1] == 3'h0 |-> ##[1:2] !timer_interrupt_input_o)
    else $error("mode 0 control word left tick output high");
  a_refresh_cw_high: assert property (cw && io_wdata_i[7:6] == 2'h1 && io_wdata_i[2:1] == 2'h2 |-> ##[1:2] refresh_pacing_o)
    else $error("mode 2 control word left refresh output low");
  a_tone_cw_high: assert property (cw && io_wdata_i[7:6] == 2'h2 && io_wdata_i[2:1] == 2'h3 |-> ##[1:2] tone_o)
    else $error("mode 3 control word left tone output low");
  a_tick_gap: assert property ($changed(timer_interrupt_input_o) && !$past(io_wr_i) && !$past(io_wr_i, 2)
    && !$past(io_wr_i, 3) |-> gap0 >= OSC_DIV * 6)
    else $error("tick output moved off the count clock");
  a_refresh_gap: assert property ($changed(refresh_pacing_o) && !$past(io_wr_i) && !$past(io_wr_i, 2)
    && !$past(io_wr_i, 3) |-> gap1 >= OSC_DIV * 6)
    else $error("refresh output moved off the count clock");
endmodule // interval_timer_checker
bind interval_timer interval_timer_checker #(.OSC_DIV(OSC_DIV)) interval_timer_checker_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .system_oscillator_clock_i(system_oscillator_clock_i),
  .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
  .io_rdata_o(io_rdata_o), .io_rd_ack_o(io_rd_ack_o), .timer_interrupt_input_o(timer_interrupt_input_o),
  .refresh_pacing_o(refresh_pacing_o), .tone_o(tone_o));

// file: bench/interval_timer_bench.sv
// self-checking bench for the interval timer
module interval_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 84; // twelve oscillator periods in 10 ns cycles
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic osc = 1'b0;
  wire [15:0] addr;
  wire        wr, rd, ack, tick, refr, tone;
  wire [7:0]  wdata, rdata;
  wire [2:0]  outs = {tone, refr, tick};
  int         error_cnt = 0, checks = 0, cyc = 0;
  logic [7:0] d;
  logic       k;
  bit         ok;
  int         t0;
  // control word, read-back command, expected status, data port
  logic [31:0] rows [7] = '{32'h34e2_f440, 32'h30e2_7040, 32'h52e4_d241, 32'hb6e8_f642,
                            32'h9be8_db42, 32'h7ce4_fc41, 32'h18e2_d840};
  always #5 clk_i = ~clk_i;
  always #34.921 osc = ~osc;
  always @(posedge clk_i) cyc <= cyc + 1;
  interval_timer interval_timer_i (.clk_i(clk_i), .resetn_i(resetn_i), .system_oscillator_clock_i(osc),
    .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wdata), .io_rdata_o(rdata),
    .io_rd_ack_o(ack), .timer_interrupt_input_o(tick), .refresh_pacing_o(refr), .tone_o(tone));
  io_host_model io_host_model_i (.clk_i(clk_i), .io_addr_o(addr), .io_wr_o(wr), .io_rd_o(rd),
    .io_wdata_o(wdata), .io_rdata_i(rdata), .io_rd_ack_i(ack));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int v, input int lo, input int hi);
    checks++;
    if (v < lo || v > hi)
    begin
      error_cnt++;
      $display("unexpected at %0t: %0d not in %0d..%0d", $time, v, lo, hi);
    end
  endtask
  task automatic wait_lvl(input int idx, input logic lvl, input int lim, output bit hit);
    hit = 0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(posedge clk_i);
      hit = (outs[idx] === lvl);
    end
  endtask
  // counter 1 counts 2 down, wraps, then status and count are latched together
  task automatic wrap(input logic [7:0] cw, input logic [7:0] hi);
    io_host_model_i.wr(16'h0043, cw);
    io_host_model_i.wr(16'h0041, 8'h02);
    io_host_model_i.wr(16'h0041, 8'h00);
    wait_lvl(1, 1'b1, 400, ok);
    chk_rng(ok, 1, 1);
    repeat (200) @(posedge clk_i);
    io_host_model_i.wr(16'h0043, 8'hc4);
    io_host_model_i.rd(16'h0041, d, k);
    chk8(d, {2'b10, cw[5:0]});
    io_host_model_i.rd(16'h0041, d, k);
    io_host_model_i.rd(16'h0041, d, k);
    chk8(d, hi);
  endtask
  task automatic print_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    print_verdict;
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    chk8({5'h00, outs}, 8'h00);
    resetn_i <= 1'b1;
    io_host_model_i.rd(16'h0043, d, k);
    chk8({7'h00, k}, 8'h00);
    foreach (rows[i])
    begin
      io_host_model_i.wr(16'h0043, rows[i][31:24]);
      io_host_model_i.wr(16'h0043, rows[i][23:16]);
      io_host_model_i.rd({8'h00, rows[i][7:0]}, d, k);
      chk8(d, rows[i][15:8]);
      chk8({7'h00, k}, 8'h01);
    end
    wrap(8'h70, 8'hff);
    wrap(8'h71, 8'h99);
    io_host_model_i.wr(16'h0043, 8'h34);
    io_host_model_i.wr(16'h0040, 8'h04);
    io_host_model_i.wr(16'h0040, 8'h00);
    wait_lvl(0, 1'b0, 1000, ok);
    t0 = cyc;
    wait_lvl(0, 1'b1, 200, ok);
    chk_rng(cyc - t0, TICK - 3, TICK + 3);
    wait_lvl(0, 1'b0, 400, ok);
    chk_rng(cyc - t0, 4 * TICK - 3, 4 * TICK + 3);
    io_host_model_i.wr(16'h0043, 8'hb6);
    io_host_model_i.wr(16'h0042, 8'h04);
    io_host_model_i.wr(16'h0042, 8'h00);
    wait_lvl(2, 1'b0, 400, ok);
    chk_rng(ok, 0, 0);
    io_host_model_i.wr(16'h0061, 8'h01);
    wait_lvl(2, 1'b0, 400, ok);
    chk_rng(ok, 1, 1);
    // reset in mid-run: outputs drop and the counters forget their count
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk8({5'h00, outs}, 8'h00);
    resetn_i <= 1'b1;
    io_host_model_i.rd(16'h0040, d, k);
    chk8(d, 8'h00);
    print_verdict;
  end
endmodule // interval_timer_bench
